//--- inc/iepr_consts.vh
// Register offsets, bit positions and reset values of the interrupt enable and priority logic
`ifndef IEPR_CONSTS_VH
`define IEPR_CONSTS_VH

// ----------------------------------------
// Register addresses and pages
// ----------------------------------------
`define IEPR_ADDR_EN_PRI 8'hA8
`define IEPR_ADDR_PRIO_PRI 8'hB8
`define IEPR_ADDR_EN_EXT 8'hE6
`define IEPR_PAGE_ZERO 8'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IEPR_RST_EN_PRI 8'h00
`define IEPR_RST_PRIO_PRI 8'h80
`define IEPR_RST_EN_EXT 8'h00

// ----------------------------------------
// Primary enable bit positions
// ----------------------------------------
`define IEPR_BIT_GLOBAL 7
`define IEPR_BIT_SERIAL_IF0 6
`define IEPR_BIT_TMR2 5
`define IEPR_BIT_UART 4
`define IEPR_BIT_TMR1 3
`define IEPR_BIT_EXT1 2
`define IEPR_BIT_TMR0 1
`define IEPR_BIT_EXT0 0

// ----------------------------------------
// Extended enable bit positions
// ----------------------------------------
`define IEPR_BIT_TMR3 7
`define IEPR_BIT_CMP1 6
`define IEPR_BIT_CMP0 5
`define IEPR_BIT_PCA 4
`define IEPR_BIT_ADC_DONE 3
`define IEPR_BIT_ADC_WIN 2
`define IEPR_BIT_RTC 1
`define IEPR_BIT_SMB 0

// ----------------------------------------
// Priority register fixed bit and source count
// ----------------------------------------
`define IEPR_BIT_PRI_FIXED 7
`define IEPR_NUM_SRC 15

`endif

//--- logic/iepr_irq_ctrl.v
// Interrupt enable and priority registers with masked request arbitration
`timescale 1ns/1ns
`include "iepr_consts.vh"
module iepr_irq_ctrl #(
  parameter NUM_SRC = `IEPR_NUM_SRC
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register bus from the core
  input wire [7:0] sfr_page,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_bit_wr,
  input wire [2:0] sfr_bit_idx,
  input wire sfr_bit_val,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  output reg sfr_hit,
  // Peripheral pending flags
  input wire ext_input_zero,
  input wire timer_zero_overflow,
  input wire ext_input_one,
  input wire timer_one_overflow,
  input wire async_port_flag,
  input wire timer_two_low_overflow,
  input wire timer_two_high_overflow,
  input wire serial_if0_flag,
  input wire two_wire_bus_flag,
  input wire rtc_alarm_flag,
  input wire window_compare_flag,
  input wire conversion_done_flag,
  input wire counter_array_flag,
  input wire comparator_zero_rise_flag,
  input wire comparator_zero_fall_flag,
  input wire comparator_one_rise_flag,
  input wire comparator_one_fall_flag,
  input wire timer_three_low_overflow,
  input wire timer_three_high_overflow,
  // Masked requests to the core
  output reg [NUM_SRC-1:0] masked_req,
  output reg [NUM_SRC-1:0] req_high,
  output reg req_valid,
  output reg [3:0] req_idx,
  output reg req_level
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire sel_en_pri;
  wire sel_prio_pri;
  wire sel_en_ext;

  assign sel_en_pri = (sfr_addr == `IEPR_ADDR_EN_PRI);
  assign sel_prio_pri = (sfr_addr == `IEPR_ADDR_PRIO_PRI) && (sfr_page == `IEPR_PAGE_ZERO);
  assign sel_en_ext = (sfr_addr == `IEPR_ADDR_EN_EXT);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  wire [7:0] interrupt_enable_primary;
  wire [7:0] interrupt_priority_primary;
  wire [7:0] interrupt_enable_extended;

  // Byte and bit writes both land here
  iepr_sfr_reg #(
    .RESET_VAL(`IEPR_RST_EN_PRI),
    .FORCE_ONE(8'h00)
  ) u_en_pri (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sel(sel_en_pri),
    .byte_wr(sfr_wr),
    .bit_wr(sfr_bit_wr),
    .bit_idx(sfr_bit_idx),
    .bit_val(sfr_bit_val),
    .wdata(sfr_wdata),
    .value(interrupt_enable_primary)
  );

  // Top bit is pinned high whatever is written
  iepr_sfr_reg #(
    .RESET_VAL(`IEPR_RST_PRIO_PRI),
    .FORCE_ONE(8'h01 << `IEPR_BIT_PRI_FIXED)
  ) u_prio_pri (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sel(sel_prio_pri),
    .byte_wr(sfr_wr),
    .bit_wr(sfr_bit_wr),
    .bit_idx(sfr_bit_idx),
    .bit_val(sfr_bit_val),
    .wdata(sfr_wdata),
    .value(interrupt_priority_primary)
  );

  iepr_sfr_reg #(
    .RESET_VAL(`IEPR_RST_EN_EXT),
    .FORCE_ONE(8'h00)
  ) u_en_ext (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sel(sel_en_ext),
    .byte_wr(sfr_wr),
    .bit_wr(sfr_bit_wr),
    .bit_idx(sfr_bit_idx),
    .bit_val(sfr_bit_val),
    .wdata(sfr_wdata),
    .value(interrupt_enable_extended)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always @* begin
    sfr_hit = sel_en_pri | sel_prio_pri | sel_en_ext;
    sfr_rdata = 8'h00;
    if (sfr_rd && sel_en_pri) begin
      sfr_rdata = interrupt_enable_primary;
    end else if (sfr_rd && sel_prio_pri) begin
      sfr_rdata = interrupt_priority_primary;
    end else if (sfr_rd && sel_en_ext) begin
      sfr_rdata = interrupt_enable_extended;
    end
  end

  // ----------------------------------------
  // Mask fields
  // ----------------------------------------
  wire global_irq_enable;
  wire serial_if0_irq_mask;
  wire timer_two_irq_mask;
  wire async_port_irq_mask;
  wire timer_one_irq_mask;
  wire ext_input_one_irq_mask;
  wire timer_zero_irq_mask;
  wire ext_input_zero_irq_mask;
  wire timer_three_irq_mask;
  wire comparator_one_irq_mask;
  wire comparator_zero_irq_mask;
  wire counter_array_irq_mask;
  wire conversion_done_irq_mask;
  wire window_compare_irq_mask;
  wire rtc_alarm_irq_mask;
  wire two_wire_bus_irq_mask;

  assign global_irq_enable = interrupt_enable_primary[`IEPR_BIT_GLOBAL];
  assign serial_if0_irq_mask = interrupt_enable_primary[`IEPR_BIT_SERIAL_IF0];
  assign timer_two_irq_mask = interrupt_enable_primary[`IEPR_BIT_TMR2];
  assign async_port_irq_mask = interrupt_enable_primary[`IEPR_BIT_UART];
  assign timer_one_irq_mask = interrupt_enable_primary[`IEPR_BIT_TMR1];
  assign ext_input_one_irq_mask = interrupt_enable_primary[`IEPR_BIT_EXT1];
  assign timer_zero_irq_mask = interrupt_enable_primary[`IEPR_BIT_TMR0];
  assign ext_input_zero_irq_mask = interrupt_enable_primary[`IEPR_BIT_EXT0];
  assign timer_three_irq_mask = interrupt_enable_extended[`IEPR_BIT_TMR3];
  assign comparator_one_irq_mask = interrupt_enable_extended[`IEPR_BIT_CMP1];
  assign comparator_zero_irq_mask = interrupt_enable_extended[`IEPR_BIT_CMP0];
  assign counter_array_irq_mask = interrupt_enable_extended[`IEPR_BIT_PCA];
  assign conversion_done_irq_mask = interrupt_enable_extended[`IEPR_BIT_ADC_DONE];
  assign window_compare_irq_mask = interrupt_enable_extended[`IEPR_BIT_ADC_WIN];
  assign rtc_alarm_irq_mask = interrupt_enable_extended[`IEPR_BIT_RTC];
  assign two_wire_bus_irq_mask = interrupt_enable_extended[`IEPR_BIT_SMB];

  // ----------------------------------------
  // Raw requests in fixed order
  // ----------------------------------------
  wire [NUM_SRC-1:0] raw_req;
  wire [NUM_SRC-1:0] src_mask;

  assign raw_req[0] = ext_input_zero;
  assign raw_req[1] = timer_zero_overflow;
  assign raw_req[2] = ext_input_one;
  assign raw_req[3] = timer_one_overflow;
  assign raw_req[4] = async_port_flag;
  assign raw_req[5] = timer_two_low_overflow | timer_two_high_overflow;
  assign raw_req[6] = serial_if0_flag;
  assign raw_req[7] = two_wire_bus_flag;
  assign raw_req[8] = rtc_alarm_flag;
  assign raw_req[9] = window_compare_flag;
  assign raw_req[10] = conversion_done_flag;
  assign raw_req[11] = counter_array_flag;
  assign raw_req[12] = comparator_zero_rise_flag | comparator_zero_fall_flag;
  assign raw_req[13] = comparator_one_rise_flag | comparator_one_fall_flag;
  assign raw_req[14] = timer_three_low_overflow | timer_three_high_overflow;

  assign src_mask[0] = ext_input_zero_irq_mask;
  assign src_mask[1] = timer_zero_irq_mask;
  assign src_mask[2] = ext_input_one_irq_mask;
  assign src_mask[3] = timer_one_irq_mask;
  assign src_mask[4] = async_port_irq_mask;
  assign src_mask[5] = timer_two_irq_mask;
  assign src_mask[6] = serial_if0_irq_mask;
  assign src_mask[7] = two_wire_bus_irq_mask;
  assign src_mask[8] = rtc_alarm_irq_mask;
  assign src_mask[9] = window_compare_irq_mask;
  assign src_mask[10] = conversion_done_irq_mask;
  assign src_mask[11] = counter_array_irq_mask;
  assign src_mask[12] = comparator_zero_irq_mask;
  assign src_mask[13] = comparator_one_irq_mask;
  assign src_mask[14] = timer_three_irq_mask;

  // ----------------------------------------
  // Gating and priority levels
  // ----------------------------------------
  wire [NUM_SRC-1:0] next_masked_req;
  wire [NUM_SRC-1:0] next_req_high;

  // Global bit overrides every per-source mask
  assign next_masked_req = global_irq_enable ? (raw_req & src_mask) : {NUM_SRC{1'b0}};
  // Extended priority lives elsewhere, so those sources sit at low level here
  assign next_req_high = {{(NUM_SRC-7){1'b0}}, interrupt_priority_primary[6:0]};

  wire pick_any;
  wire [3:0] pick_idx;
  wire pick_level;

  iepr_prio_pick #(
    .NUM_SRC(NUM_SRC)
  ) u_pick (
    .req(next_masked_req),
    .high(next_req_high),
    .any(pick_any),
    .idx(pick_idx),
    .level(pick_level)
  );

  // ----------------------------------------
  // Registered outputs, refreshed each cycle
  // ----------------------------------------
  // Registered so a write reaches these outputs one edge after the register takes it, not mid-cycle
  always @(posedge sys_clk) begin
    if (!nrst) begin
      masked_req <= {NUM_SRC{1'b0}};
      req_high <= {NUM_SRC{1'b0}};
      req_valid <= 1'b0;
      req_idx <= 4'h0;
      req_level <= 1'b0;
    end else begin
      masked_req <= next_masked_req;
      req_high <= next_req_high;
      req_valid <= pick_any;
      req_idx <= pick_idx;
      req_level <= pick_level;
    end
  end

endmodule // iepr_irq_ctrl

//--- logic/iepr_prio_pick.v
// Two-level fixed-order pick among masked interrupt requests
`timescale 1ns/1ns
module iepr_prio_pick #(
  parameter NUM_SRC = 15
) (
  // Requests
  input wire [NUM_SRC-1:0] req,
  input wire [NUM_SRC-1:0] high,
  // Result
  output wire any,
  output wire [3:0] idx,
  output wire level
);

  // Lowest index wins inside a level
  function [4:0] first_set;
    input [NUM_SRC-1:0] v;
    integer i;
    begin
      first_set = 5'h00;
      for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  wire [4:0] hi_pick;
  wire [4:0] lo_pick;

  assign hi_pick = first_set(req & high);
  assign lo_pick = first_set(req & ~high);
  // High level beats low level
  assign any = hi_pick[4] | lo_pick[4];
  assign level = hi_pick[4];
  assign idx = hi_pick[4] ? hi_pick[3:0] : lo_pick[3:0];

endmodule // iepr_prio_pick

//--- logic/iepr_sfr_reg.v
// One bit-addressable special function register with a fixed-one mask
`timescale 1ns/1ns
module iepr_sfr_reg #(
  parameter [7:0] RESET_VAL = 8'h00,
  parameter [7:0] FORCE_ONE = 8'h00
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Access
  input wire sel,
  input wire byte_wr,
  input wire bit_wr,
  input wire [2:0] bit_idx,
  input wire bit_val,
  input wire [7:0] wdata,
  // State
  output wire [7:0] value
);

  reg [7:0] store;
  reg [7:0] next_store;

  // ----------------------------------------
  // Byte and single-bit writes
  // ----------------------------------------
  always @* begin
    next_store = store;
    if (sel && byte_wr) begin
      next_store = wdata;
    end else if (sel && bit_wr) begin
      next_store[bit_idx] = bit_val;
    end
    // Fixed bits never hold a written value
    next_store = next_store | FORCE_ONE;
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      store <= RESET_VAL;
    end else begin
      store <= next_store;
    end
  end

  assign value = store;

endmodule // iepr_sfr_reg

//--- tb/iepr_irq_ctrl_monitor.sv
// Checker of register decode and request arbitration at the block ports
`timescale 1ns/1ns
module iepr_irq_monitor #(
  parameter NUM_SRC = 15
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Register bus
  input wire [7:0] sfr_page,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire sfr_hit,
  // Requests
  input wire ext_input_zero,
  input wire [NUM_SRC-1:0] masked_req,
  input wire [NUM_SRC-1:0] req_high,
  input wire req_valid,
  input wire [3:0] req_idx,
  input wire req_level
);
  // ------
  // Helpers
  // ------
  wire [NUM_SRC-1:0] one = {{(NUM_SRC-1){1'b0}}, 1'b1};
  wire [NUM_SRC-1:0] below = (one << req_idx) - one;
  wire [NUM_SRC-1:0] same = req_level ? req_high : ~req_high;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ------
  // Properties
  // ------
  property p_page_only; sfr_addr == 8'hB8 && sfr_page != 8'h00 |-> !sfr_hit; endproperty
  a_page_only: assert property (p_page_only) else $error("priority hit off page zero");
  property p_all_pages; sfr_addr == 8'hA8 || sfr_addr == 8'hE6 |-> sfr_hit; endproperty
  a_all_pages: assert property (p_all_pages) else $error("enable register missed");
  property p_top_one; sfr_rd && sfr_hit && sfr_addr == 8'hB8 |-> sfr_rdata[7]; endproperty
  a_top_one: assert property (p_top_one) else $error("priority top bit low");
  property p_unmapped; !sfr_hit |-> sfr_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("read data without hit");
  // Two edges: register first, then the request outputs
  property p_global_off;
    sfr_wr && sfr_addr == 8'hA8 && !sfr_wdata[7] |-> ##2 masked_req == '0;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request past global off");
  property p_flag_cause; masked_req[0] |-> $past(ext_input_zero); endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("request without flag");
  property p_valid; req_valid == (|masked_req); endproperty
  a_valid: assert property (p_valid) else $error("valid disagrees with requests");
  property p_high_first; req_valid && !req_level |-> (masked_req & req_high) == '0; endproperty
  a_high_first: assert property (p_high_first) else $error("low won over high");
  property p_winner;
    req_valid |-> masked_req[req_idx] && req_level == req_high[req_idx];
  endproperty
  a_winner: assert property (p_winner) else $error("winner not requesting");
  property p_lowest; req_valid |-> (masked_req & below & same) == '0; endproperty
  a_lowest: assert property (p_lowest) else $error("lower order number skipped");
  property p_idle; !req_valid |-> req_idx == 4'h0 && !req_level; endproperty
  a_idle: assert property (p_idle) else $error("winner shown while idle");
endmodule // iepr_irq_monitor

bind iepr_irq_ctrl iepr_irq_monitor #(.NUM_SRC(NUM_SRC)) iepr_irq_monitor_inst (
  .sys_clk(sys_clk), .nrst(nrst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .ext_input_zero(ext_input_zero), .masked_req(masked_req),
  .req_high(req_high), .req_valid(req_valid), .req_idx(req_idx), .req_level(req_level)
);

//--- tb/iepr_irq_ctrl_tb.sv
// Self-checking bench for the interrupt enable and priority logic
`timescale 1ns/1ns
module iepr_irq_ctrl_tb;
  // ------
  // Signals
  // ------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_page = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, sfr_rd = 1'b0;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic [7:0] en_s, eie_s, pr_s;
  wire [18:0] fl;
  wire [7:0] sfr_rdata;
  wire [14:0] masked_req, req_high;
  wire [3:0] req_idx;
  wire sfr_hit, req_valid, req_level;
  int err_count = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  iepr_src_model iepr_src_model_inst (.sys_clk(sys_clk), .flags(fl));
  iepr_irq_ctrl iepr_irq_ctrl_inst (
    .sys_clk(sys_clk), .nrst(nrst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
    .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext_input_zero(fl[0]),
    .timer_zero_overflow(fl[1]), .ext_input_one(fl[2]), .timer_one_overflow(fl[3]),
    .async_port_flag(fl[4]), .timer_two_low_overflow(fl[5]),
    .timer_two_high_overflow(fl[6]), .serial_if0_flag(fl[7]), .two_wire_bus_flag(fl[8]),
    .rtc_alarm_flag(fl[9]), .window_compare_flag(fl[10]), .conversion_done_flag(fl[11]),
    .counter_array_flag(fl[12]), .comparator_zero_rise_flag(fl[13]),
    .comparator_zero_fall_flag(fl[14]), .comparator_one_rise_flag(fl[15]),
    .comparator_one_fall_flag(fl[16]), .timer_three_low_overflow(fl[17]),
    .timer_three_high_overflow(fl[18]), .masked_req(masked_req), .req_high(req_high),
    .req_valid(req_valid), .req_idx(req_idx), .req_level(req_level)
  );
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst();
    @(posedge sys_clk);
    #1;
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    en_s = 8'h00;
    eie_s = 8'h00;
    pr_s = 8'h80;
  endtask
  // Bit mode takes the index from d[2:0] and the value from d[3]
  task automatic acc(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d,
                     input logic bm);
    @(posedge sys_clk);
    #1;
    sfr_page = pg;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_bit_idx = d[2:0];
    sfr_bit_val = d[3];
    sfr_wr = !bm;
    sfr_bit_wr = bm;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_bit_wr = 1'b0;
  endtask
  // Expected value packs the hit flag above the read data
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [8:0] exp);
    @(posedge sys_clk);
    #1;
    sfr_page = pg;
    sfr_addr = a;
    sfr_rd = 1'b1;
    #2;
    chk({7'h00, sfr_hit, sfr_rdata}, {7'h00, exp});
    @(posedge sys_clk);
    #1;
    sfr_rd = 1'b0;
  endtask
  task automatic setr(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    acc(8'h00, 8'hA8, a, 1'b0);
    acc(8'h00, 8'hE6, b, 1'b0);
    acc(8'h00, 8'hB8, c, 1'b0);
    en_s = a;
    eie_s = b;
    pr_s = c | 8'h80;
  endtask
  task automatic step(input logic [18:0] f);
    logic [14:0] s;
    logic [14:0] m;
    logic [3:0] w;
    logic lv;
    iepr_src_model_inst.drive(f);
    repeat (2) @(posedge sys_clk);
    #2;
    s = {f[17] | f[18], f[15] | f[16], f[13] | f[14], f[12:7], f[5] | f[6], f[4:0]};
    m = en_s[7] ? s & {eie_s, en_s[6:0]} : 15'h0000;
    lv = |(m[6:0] & pr_s[6:0]);
    w = 4'h0;
    for (int i = 14; i >= 0; i--)
      if (m[i] && ((i < 7) && pr_s[i]) == lv) w = 4'(i);
    chk({1'b0, masked_req}, {1'b0, m});
    chk({1'b0, req_high}, {9'h000, pr_s[6:0]});
    chk({10'h000, req_valid, req_level, req_idx}, {10'h000, |m, lv, w});
  endtask
  // ------
  // Scenarios
  // ------
  task automatic s_regs();
    rd(8'h00, 8'hA8, 9'h100);
    rd(8'h00, 8'hB8, 9'h180);
    rd(8'h00, 8'hE6, 9'h100);
    rd(8'h00, 8'h55, 9'h000);
  endtask
  task automatic s_pages();
    acc(8'h03, 8'hA8, 8'h5A, 1'b0);
    acc(8'h07, 8'hE6, 8'hA5, 1'b0);
    acc(8'h03, 8'hB8, 8'h7F, 1'b0);
    rd(8'h03, 8'hB8, 9'h000);
    rd(8'h09, 8'hA8, 9'h15A);
    rd(8'h09, 8'hE6, 9'h1A5);
    rd(8'h00, 8'hB8, 9'h180);
  endtask
  task automatic s_bits();
    acc(8'h00, 8'hB8, 8'h7F, 1'b0);
    rd(8'h00, 8'hB8, 9'h1FF);
    acc(8'h00, 8'hB8, 8'h07, 1'b1);
    acc(8'h00, 8'hB8, 8'h03, 1'b1);
    rd(8'h00, 8'hB8, 9'h1F7);
    acc(8'h00, 8'hA8, 8'h08, 1'b1);
    acc(8'h05, 8'hA8, 8'h04, 1'b1);
    rd(8'h00, 8'hA8, 9'h14B);
    acc(8'h04, 8'hE6, 8'h09, 1'b1);
    rd(8'h00, 8'hE6, 9'h1A7);
  endtask
  // Checkerboard masks show each source bit both open and shut
  task automatic s_gate();
    logic [23:0] combo [5] = '{24'hFFFF00, 24'h7FFF55, 24'hFFFF55, 24'hAA5500, 24'hD5AA2A};
    for (int c = 0; c < 5; c++) begin
      setr(combo[c][23:16], combo[c][15:8], combo[c][7:0]);
      for (int i = 0; i < 19; i++)
        step(19'h00001 << i);
    end
  endtask
  task automatic s_prio();
    setr(8'hFF, 8'hFF, 8'h00);
    for (int k = 0; k < 8; k++) begin
      acc(8'h00, 8'hB8, 8'h01 << k, 1'b0);
      pr_s = (8'h01 << k) | 8'h80;
      step(19'h7FFFF);
    end
    step(19'h40100);
    setr(8'hF7, 8'hFE, 8'h10);
    step(19'h7FFFF);
  endtask
  // One edge to the register, a second to the outputs
  task automatic s_latency();
    setr(8'h00, 8'h00, 8'h00);
    step(19'h00001);
    acc(8'h00, 8'hA8, 8'h81, 1'b0);
    chk({1'b0, masked_req}, 16'h0000);
    @(posedge sys_clk);
    #2;
    chk({1'b0, masked_req}, 16'h0001);
    acc(8'h00, 8'hA8, 8'h01, 1'b0);
    en_s = 8'h01;
    step(19'h00001);
  endtask
  initial begin
    rst();
    s_regs();
    s_pages();
    s_bits();
    s_gate();
    s_prio();
    s_latency();
    rst();
    s_regs();
    step(19'h7FFFF);
    tally_and_finish();
  end
  initial begin
    #1000000;
    err_count++;
    tally_and_finish();
  end
endmodule // iepr_irq_ctrl_tb

//--- tb/iepr_src_model.sv
// Model of the peripheral pending flags feeding the block
`timescale 1ns/1ns
module iepr_src_model (
  // Clock
  input wire sys_clk,
  // Pending flags
  output logic [18:0] flags
);
  initial flags = 19'h00000;
  // Moves just after an edge, as same-clock peripheral logic would
  task automatic drive(input logic [18:0] v);
    @(posedge sys_clk);
    #1;
    flags = v;
  endtask
endmodule // iepr_src_model
